// >>> design/cbf_fetch_parse.sv
// Behaviour
// - a ring is at most 2MB long; length setting stops there.
// - batch end address names the last valid qword, inclusive.
// - batch addresses and lengths span the full 4GB range.
// - batches are fetched contiguously, entered by a batch start command.
// - insert buffer pauses restore at cacheline offset, runs, then resumes.
// - insert buffer base and size from pointer, offset from own setting; here size comes from its own REG_INS_SIZE register.
// - workaround fetches use the submitting function's global table.
// - post-restore batch starts after restore completes; runs like batch.
// - post-restore batch finishes on its batch end command.
// - disabled post-restore pointer skips that batch.
// - post-restore pointer comes from each context's own image.
// - workaround buffers run before any ring command of the context.
// - first dword of each command is the header with client field.
// - bits 31:29: 000 memory-interface, 010/011 engine, others reserved.
// - client field steers processing and data routing.
// - command length in whole dwords, implied, fixed or variable.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbf_fetch_parse (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // register port
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [31:0]             reg_rdata_o,
  // memory fetch
  output logic                    mem_req_o,
  output logic [31:0]             mem_addr_o,
  output logic                    mem_global_translation_table_o,
  input  wire logic               mem_ack_i,
  input  wire logic [31:0]        mem_data_i,
  // context restore stream
  input  wire logic               rst_word_i,
  input  wire logic [31:0]        rst_data_i,
  output logic                    rst_ready_o,
  // client routing
  output logic                    cmd_valid_o,
  output logic [31:0]             cmd_data_o,
  output logic                    cmd_first_o,
  output cbf_pkg::cbf_client_t    cmd_client_o,
  output logic                    cmd_err_o
);
  import cbf_pkg::*;

  typedef enum logic [2:0] {
    CBF_IDLE, CBF_RESTORE, CBF_INSERT, CBF_POST, CBF_EXEC
  } cbf_state_t;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ring_base_reg, ring_base_next;
  logic [RING_LEN_W:0] ring_len_reg, ring_len_next;
  logic [31:0] ring_tail_reg, ring_tail_next;
  logic [31:0] head_reg, head_next;
  logic        run_reg, run_next, ins_en_reg, ins_en_next;
  logic [31:0] ins_ptr_reg, ins_ptr_next, ins_size_reg, ins_size_next;
  logic [31:0] ins_ofs_reg, ins_ofs_next, post_ptr_reg, post_ptr_next;
  logic [31:0] rst_len_reg, rst_len_next, rst_cnt_reg, rst_cnt_next;
  logic [31:0] ptr_reg, ptr_next, end_reg, end_next;
  logic [31:0] rd_reg, rd_next;
  logic [7:0]  left_reg, left_next;
  logic        batch_hi_reg, batch_hi_next, bb_arg_reg, bb_arg_next;
  logic        err_reg, err_next;
  cbf_src_t    src_reg, src_next, ret_reg, ret_next;
  cbf_state_t  st_reg, st_next;
  logic        vld_reg, vld_next, first_reg, first_next;
  logic [31:0] dat_reg, dat_next;
  cbf_client_t cli_reg, cli_next, cur_cli_reg, cur_cli_next;

  logic        hdr_start, hdr_end;
  logic [7:0]  hdr_len;
  cbf_client_t hdr_cli;

  // header classification of the incoming fetch word
  cbf_hdr_decode u_dec (
    .hdr_i         (mem_data_i),
    .client_o      (hdr_cli),
    .len_dw_o      (hdr_len),
    .is_bb_start_o (hdr_start),
    .is_bb_end_o   (hdr_end)
  );

  // ring wraps at base plus length
  function automatic logic [31:0] ring_next(input logic [31:0] h,
                                            input logic [RING_LEN_W:0] l);
    logic [31:0] n;
    n = h + DW_BYTES;
    ring_next = (n >= 32'(l)) ? 32'h0 : n;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    ring_base_next = ring_base_reg;
    ring_len_next  = ring_len_reg;
    ring_tail_next = ring_tail_reg;
    head_next      = head_reg;
    run_next       = run_reg;
    ins_en_next    = ins_en_reg;
    ins_ptr_next   = ins_ptr_reg;
    ins_size_next  = ins_size_reg;
    ins_ofs_next   = ins_ofs_reg;
    post_ptr_next  = post_ptr_reg;
    rst_len_next   = rst_len_reg;
    rst_cnt_next   = rst_cnt_reg;
    ptr_next       = ptr_reg;
    end_next       = end_reg;
    left_next      = left_reg;
    batch_hi_next  = batch_hi_reg;
    bb_arg_next    = bb_arg_reg;
    err_next       = err_reg;
    src_next       = src_reg;
    ret_next       = ret_reg;
    st_next        = st_reg;
    vld_next       = 1'b0;
    first_next     = 1'b0;
    dat_next       = dat_reg;
    cli_next       = cli_reg;
    cur_cli_next   = cur_cli_reg;
    rd_next        = 32'h0;

    // register writes; base low bits forced to keep 4KB alignment
    if (reg_wr_i) begin
      if (reg_addr_i == REG_RING_BASE) begin
        ring_base_next = {reg_wdata_i[31:RING_ALIGN_B],
                          {RING_ALIGN_B{1'b0}}};
      end else if (reg_addr_i == REG_RING_LEN) begin
        // clamp at 2MB
        ring_len_next = (reg_wdata_i > RING_MAX_B) ?
                        RING_MAX_B[RING_LEN_W:0] :
                        reg_wdata_i[RING_LEN_W:0];
      end else if (reg_addr_i == REG_RING_TAIL) begin
        ring_tail_next = reg_wdata_i;
      end else if (reg_addr_i == REG_CTRL) begin
        run_next    = reg_wdata_i[CTRL_RUN];
        ins_en_next = reg_wdata_i[CTRL_INS_EN];
      end else if (reg_addr_i == REG_INS_PTR) begin
        ins_ptr_next = {reg_wdata_i[31:CL_ALIGN_B], {CL_ALIGN_B{1'b0}}};
      end else if (reg_addr_i == REG_INS_SIZE) begin
        ins_size_next = reg_wdata_i;
      end else if (reg_addr_i == REG_INS_OFS) begin
        ins_ofs_next = {reg_wdata_i[31:CL_ALIGN_B], {CL_ALIGN_B{1'b0}}};
      end else if (reg_addr_i == REG_POST_PTR) begin
        post_ptr_next = reg_wdata_i;
      end else if (reg_addr_i == REG_RST_LEN) begin
        rst_len_next = reg_wdata_i;
      end else if (reg_addr_i == REG_STATUS) begin
        err_next = err_reg & ~reg_wdata_i[0];
      end
    end

    // register reads, data in next cycle
    if (reg_rd_i) begin
      if (reg_addr_i == REG_RING_BASE)      rd_next = ring_base_reg;
      else if (reg_addr_i == REG_RING_LEN)  rd_next = 32'(ring_len_reg);
      else if (reg_addr_i == REG_RING_TAIL) rd_next = ring_tail_reg;
      else if (reg_addr_i == REG_CTRL)
        rd_next = {29'h0, ins_en_reg, 1'b0, run_reg};
      else if (reg_addr_i == REG_INS_PTR)   rd_next = ins_ptr_reg;
      else if (reg_addr_i == REG_INS_SIZE)  rd_next = ins_size_reg;
      else if (reg_addr_i == REG_INS_OFS)   rd_next = ins_ofs_reg;
      else if (reg_addr_i == REG_POST_PTR)  rd_next = post_ptr_reg;
      else if (reg_addr_i == REG_STATUS)
        rd_next = {27'h0, 1'(st_reg), src_reg, (st_reg == CBF_IDLE),
                   err_reg};
      else if (reg_addr_i == REG_HEAD)      rd_next = head_reg;
      else if (reg_addr_i == REG_RST_LEN)   rd_next = rst_len_reg;
    end

    // ****************************************
    // fetch and parse sequencing
    // ****************************************
    case (st_reg)
      CBF_IDLE: begin
        if (reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_LOAD]) begin
          // context load: no ring command until workarounds done
          st_next      = CBF_RESTORE;
          rst_cnt_next = 32'h0;
        end else if (run_reg && head_reg != ring_tail_reg) begin
          st_next  = CBF_EXEC;
          src_next = CBF_SRC_RING;
        end
      end
      CBF_RESTORE: begin
        if (rst_cnt_reg >= rst_len_reg) begin
          // restore done: post batch unless pointer disabled
          if (post_ptr_reg[PTR_EN_BIT]) begin
            st_next  = CBF_EXEC;
            src_next = CBF_SRC_POST;
            ptr_next = {post_ptr_reg[31:CL_ALIGN_B], {CL_ALIGN_B{1'b0}}};
            end_next = 32'hffff_fff8;      // open ended until batch end
            left_next = 8'h0;
          end else begin
            st_next = CBF_IDLE;
          end
        end else if (ins_en_reg && rst_cnt_reg == ins_ofs_reg &&
                     ins_size_reg != 32'h0) begin
          // pause restore at the cacheline offset
          st_next   = CBF_EXEC;
          src_next  = CBF_SRC_INSERT;
          ptr_next  = ins_ptr_reg;
          end_next  = ins_ptr_reg + ins_size_reg - QW_BYTES;
          left_next = 8'h0;
          ins_en_next = 1'b0;              // one shot per restore
        end else if (rst_word_i) begin
          // image word at the REG_POST_PTR offset carries the per-context post pointer
          if (rst_cnt_reg == 32'(REG_POST_PTR) * DW_BYTES)
            post_ptr_next = rst_data_i;
          rst_cnt_next = rst_cnt_reg + DW_BYTES;
        end
      end
      CBF_EXEC: begin
        if (mem_ack_i) begin
          dat_next = mem_data_i;
          vld_next = 1'b1;
          if (src_reg == CBF_SRC_RING)
            head_next = ring_next(head_reg, ring_len_reg);
          else
            ptr_next = ptr_reg + DW_BYTES;
          if (bb_arg_reg) begin
            // batch start operand: qword target, contiguous fetch
            vld_next = 1'b0;
            bb_arg_next = 1'b0;
            ret_next = src_reg;
            src_next = (src_reg == CBF_SRC_RING) ? CBF_SRC_BATCH : src_reg;
            ptr_next = {mem_data_i[31:3], 3'h0};
            end_next = 32'hffff_fff8;      // 4GB span
          end else if (left_reg != 8'h0) begin
            left_next = left_reg - 8'h1;   // payload dwords
            cli_next  = cur_cli_reg;
          end else begin
            // header dword: client routes it
            first_next = 1'b1;
            cli_next   = hdr_cli;
            cur_cli_next = hdr_cli;
            left_next  = hdr_len - 8'h1;   // length in dwords
            if (hdr_cli == CBF_CLI_NONE) begin
              // reserved type: flagged, no client
              err_next = 1'b1;
              vld_next = 1'b0;
              left_next = 8'h0;
            end else if (hdr_start) begin
              bb_arg_next = 1'b1;
              left_next = 8'h0;
              vld_next  = 1'b0;
            end else if (hdr_end && src_reg != CBF_SRC_RING) begin
              // batch end leaves the buffer
              vld_next = 1'b0;
              left_next = 8'h0;
              if (src_reg == CBF_SRC_INSERT) begin
                st_next = CBF_RESTORE;     // resume restore
                src_next = CBF_SRC_RING;
              end else if (src_reg == CBF_SRC_POST) begin
                st_next = CBF_IDLE;
                src_next = CBF_SRC_RING;
              end else begin
                src_next = ret_reg;
              end
            end
          end
          // inclusive end address: last valid qword
          if (src_reg == CBF_SRC_INSERT &&
              ptr_reg >= end_reg + DW_BYTES && left_next == 8'h0 &&
              st_next == CBF_EXEC) begin
            st_next  = CBF_RESTORE;
            src_next = CBF_SRC_RING;
          end
          if (src_reg == CBF_SRC_RING && src_next == CBF_SRC_RING &&
              ring_next(head_reg, ring_len_reg) == ring_tail_reg &&
              left_next == 8'h0 && !bb_arg_next)
            st_next = CBF_IDLE;
          // back in the ring from a batch with nothing queued
          if (src_reg == CBF_SRC_BATCH && src_next == CBF_SRC_RING &&
              st_next == CBF_EXEC && head_reg == ring_tail_reg)
            st_next = CBF_IDLE;
        end
      end
      default: st_next = CBF_IDLE;
    endcase
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ring_base_reg <= 32'h0;
      ring_len_reg  <= '0;
      ring_tail_reg <= 32'h0;
      head_reg      <= 32'h0;
      run_reg       <= 1'b0;
      ins_en_reg    <= 1'b0;
      ins_ptr_reg   <= 32'h0;
      ins_size_reg  <= 32'h0;
      ins_ofs_reg   <= 32'h0;
      post_ptr_reg  <= 32'h0;
      rst_len_reg   <= 32'h0;
      rst_cnt_reg   <= 32'h0;
      ptr_reg       <= 32'h0;
      end_reg       <= 32'h0;
      left_reg      <= 8'h0;
      batch_hi_reg  <= 1'b0;
      bb_arg_reg    <= 1'b0;
      err_reg       <= 1'b0;
      src_reg       <= CBF_SRC_RING;
      ret_reg       <= CBF_SRC_RING;
      st_reg        <= CBF_IDLE;
      vld_reg       <= 1'b0;
      first_reg     <= 1'b0;
      dat_reg       <= 32'h0;
      cli_reg       <= CBF_CLI_NONE;
      cur_cli_reg   <= CBF_CLI_NONE;
      rd_reg        <= 32'h0;
    end else begin
      ring_base_reg <= ring_base_next;
      ring_len_reg  <= ring_len_next;
      ring_tail_reg <= ring_tail_next;
      head_reg      <= head_next;
      run_reg       <= run_next;
      ins_en_reg    <= ins_en_next;
      ins_ptr_reg   <= ins_ptr_next;
      ins_size_reg  <= ins_size_next;
      ins_ofs_reg   <= ins_ofs_next;
      post_ptr_reg  <= post_ptr_next;
      rst_len_reg   <= rst_len_next;
      rst_cnt_reg   <= rst_cnt_next;
      ptr_reg       <= ptr_next;
      end_reg       <= end_next;
      left_reg      <= left_next;
      batch_hi_reg  <= batch_hi_next;
      bb_arg_reg    <= bb_arg_next;
      err_reg       <= err_next;
      src_reg       <= src_next;
      ret_reg       <= ret_next;
      st_reg        <= st_next;
      vld_reg       <= vld_next;
      first_reg     <= first_next;
      dat_reg       <= dat_next;
      cli_reg       <= cli_next;
      cur_cli_reg   <= cur_cli_next;
      rd_reg        <= rd_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_o  = rd_reg;
  // not ready on cycles that branch away, so no image word is lost
  assign rst_ready_o  = (st_reg == CBF_RESTORE) &&
                        (rst_cnt_reg < rst_len_reg) &&
                        !(ins_en_reg && rst_cnt_reg == ins_ofs_reg &&
                          ins_size_reg != 32'h0);
  assign mem_req_o    = (st_reg == CBF_EXEC);
  // workaround buffers always go through the global table
  assign mem_global_translation_table_o = (src_reg == CBF_SRC_INSERT) ||
                        (src_reg == CBF_SRC_POST);
  assign mem_addr_o   = (src_reg == CBF_SRC_RING) ?
                        ring_base_reg + head_reg : ptr_reg;
  assign cmd_valid_o  = vld_reg;
  assign cmd_data_o   = dat_reg;
  assign cmd_first_o  = first_reg;
  assign cmd_client_o = cli_reg;
  assign cmd_err_o    = err_reg;
endmodule
`default_nettype wire

// >>> design/cbf_pkg.sv
package cbf_pkg;
  // ****************************************
  // header decode
  // ****************************************
  localparam int unsigned TYPE_MSB     = 31;
  localparam int unsigned TYPE_LSB     = 29;
  localparam logic [2:0]  TYPE_MEMIF   = 3'h0;
  localparam logic [2:0]  TYPE_ENG_A   = 3'h2;
  localparam logic [2:0]  TYPE_ENG_B   = 3'h3;
  localparam int unsigned OPC_MSB      = 28;
  localparam int unsigned OPC_LSB      = 23;
  localparam logic [5:0]  OPC_BB_END   = 6'h0a;
  localparam logic [5:0]  OPC_BB_START = 6'h31;
  localparam int unsigned LEN_MSB      = 7;
  localparam int unsigned LEN_LSB      = 0;
  // memory-interface opcodes below this are single dword
  localparam logic [5:0]  OPC_MULTI    = 6'h10;
  // variable length field holds total dwords minus two
  localparam logic [7:0]  LEN_BIAS     = 8'h02;

  // ****************************************
  // buffer geometry
  // ****************************************
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned RING_ALIGN_B = 12;       // 4KB boundary
  localparam int unsigned RING_LEN_W   = 21;       // 2MB ceiling
  localparam logic [31:0] RING_MAX_B   = 32'h0020_0000;
  localparam logic [31:0] QW_BYTES     = 32'h0000_0008;
  localparam logic [31:0] DW_BYTES     = 32'h0000_0004;
  localparam int unsigned CL_ALIGN_B   = 6;        // cacheline offset

  // ****************************************
  // register port
  // ****************************************
  localparam logic [3:0] REG_RING_BASE  = 4'h0;
  localparam logic [3:0] REG_RING_LEN   = 4'h1;
  localparam logic [3:0] REG_RING_TAIL  = 4'h2;
  localparam logic [3:0] REG_CTRL       = 4'h3;
  localparam logic [3:0] REG_INS_PTR    = 4'h4;
  localparam logic [3:0] REG_INS_SIZE   = 4'h5;
  localparam logic [3:0] REG_INS_OFS    = 4'h6;
  localparam logic [3:0] REG_POST_PTR   = 4'h7;
  localparam logic [3:0] REG_STATUS     = 4'h8;
  localparam logic [3:0] REG_HEAD       = 4'h9;
  localparam logic [3:0] REG_RST_LEN    = 4'ha;
  localparam int unsigned CTRL_RUN      = 0;
  localparam int unsigned CTRL_LOAD     = 1;       // write 1: load context
  localparam int unsigned CTRL_INS_EN   = 2;
  localparam int unsigned PTR_EN_BIT    = 0;       // post pointer enable

  // ****************************************
  // fetch routes and states
  // ****************************************
  typedef enum logic [1:0] {
    CBF_CLI_MEMIF,
    CBF_CLI_ENGINE,
    CBF_CLI_NONE
  } cbf_client_t;

  typedef enum logic [1:0] {
    CBF_SRC_RING,
    CBF_SRC_BATCH,
    CBF_SRC_INSERT,
    CBF_SRC_POST
  } cbf_src_t;
endpackage

// >>> design/cbf_hdr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cbf_hdr_decode (
  // header dword
  input  wire logic [31:0]        hdr_i,
  // classification
  output cbf_pkg::cbf_client_t    client_o,
  output logic [7:0]              len_dw_o,
  output logic                    is_bb_start_o,
  output logic                    is_bb_end_o
);
  import cbf_pkg::*;

  logic [2:0] typ;
  logic [5:0] opc;

  // ****************************************
  // type field and length
  // ****************************************
  always_comb begin
    typ           = hdr_i[TYPE_MSB:TYPE_LSB];
    opc           = hdr_i[OPC_MSB:OPC_LSB];
    client_o      = CBF_CLI_NONE;
    len_dw_o      = 8'h01;
    is_bb_start_o = 1'b0;
    is_bb_end_o   = 1'b0;
    if (typ == TYPE_MEMIF) begin
      client_o      = CBF_CLI_MEMIF;
      is_bb_end_o   = (opc == OPC_BB_END);
      is_bb_start_o = (opc == OPC_BB_START);
      // short opcodes imply one dword, others carry a length
      if (opc >= OPC_MULTI)
        len_dw_o = hdr_i[LEN_MSB:LEN_LSB] + LEN_BIAS;
    end else if (typ == TYPE_ENG_A || typ == TYPE_ENG_B) begin
      client_o = CBF_CLI_ENGINE;
      len_dw_o = hdr_i[LEN_MSB:LEN_LSB] + LEN_BIAS;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/cbf_fetch_parse_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cbf_fetch_parse_assertions (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  // register port
  input wire logic [3:0]           reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  // fetch and restore
  input wire logic                 mem_req_o,
  input wire logic                 mem_global_translation_table_o,
  input wire logic                 mem_ack_i,
  input wire logic [31:0]          mem_data_i,
  input wire logic                 rst_ready_o,
  // client routing
  input wire logic                 cmd_valid_o,
  input wire logic [31:0]          cmd_data_o,
  input wire logic                 cmd_first_o,
  input wire cbf_pkg::cbf_client_t cmd_client_o,
  input wire logic                 cmd_err_o
);
  import cbf_pkg::*;
  // ****************************************
  // routing and restore order
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fetch; mem_req_o && mem_ack_i; endsequence
  sequence s_hdr; cmd_valid_o && cmd_first_o; endsequence
  property p_hdr_type; s_hdr |-> cmd_data_o[31:29] inside {3'h0, 3'h2, 3'h3};
  endproperty
  a_hdr_type: assert property (p_hdr_type) else $error("reserved routed");
  property p_hdr_cli; s_hdr |-> cmd_client_o ==
    ((cmd_data_o[31:29] == TYPE_MEMIF) ? CBF_CLI_MEMIF : CBF_CLI_ENGINE);
  endproperty
  a_hdr_cli: assert property (p_hdr_cli) else $error("bad client");
  property p_route; s_fetch ##1 cmd_valid_o |-> cmd_data_o == $past(mem_data_i);
  endproperty
  a_route: assert property (p_route) else $error("routed data differs");
  property p_cause; cmd_valid_o |-> $past(mem_req_o) && $past(mem_ack_i);
  endproperty
  a_cause: assert property (p_cause) else $error("dword without fetch");
  // error flag only drops on a one written to the status bit
  property p_err; cmd_err_o && !(reg_wr_i && reg_addr_i == REG_STATUS &&
    reg_wdata_i[0]) |=> cmd_err_o;
  endproperty
  a_err: assert property (p_err) else $error("error flag lost");
  property p_ring_wait; rst_ready_o |->
    !mem_req_o || mem_global_translation_table_o;
  endproperty
  a_ring_wait: assert property (p_ring_wait) else $error("ring early");
  property p_pause; mem_req_o && mem_global_translation_table_o |->
    !rst_ready_o;
  endproperty
  a_pause: assert property (p_pause) else $error("restore not paused");
  property p_len_cap; reg_rd_i && reg_addr_i == REG_RING_LEN |=>
    reg_rdata_o <= RING_MAX_B;
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("ring too long");
endmodule
bind cbf_fetch_parse cbf_fetch_parse_assertions u_chk (.*);
`default_nettype wire

// >>> testbench/cbf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbf_mem_model (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // fetch side
  input wire logic        mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [1:0]  gap_i,
  output logic            ack_o,
  output logic [31:0]     data_o
);
  // flat linear store, coherent, so no snoop hint is needed
  logic [31:0] mem [4096];
  logic [31:0] last_reg;
  logic [1:0]  wait_reg;
  initial foreach (mem[i]) mem[i] = 32'hffff_ffff;
  // gap_i idle cycles between answers; zero gives back to back acks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      wait_reg <= 2'h0;
      last_reg <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      if (ack_o) last_reg <= data_o;
      if (mem_req_o && wait_reg >= gap_i) begin
        ack_o <= 1'b1;
        wait_reg <= 2'h0;
      end else if (mem_req_o) begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
  // data line shows junk outside an answer so stale values never match
  assign data_o = ack_o ? mem[mem_addr_o[13:2]] : ~last_reg;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cbf_pkg::*;
  typedef struct packed {
    logic [31:0] hdr;
    logic [3:0]  len;
    logic [3:0]  dw;
    cbf_client_t cli;
    logic        err;
  } cbf_row_t;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] rst_data_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        rst_word_i = 1'b0;
  logic [1:0]  gap = 2'h0;
  logic [31:0] reg_rdata_o, mem_addr_o, mem_data_i, cmd_data_o, f_dat, tail;
  logic        mem_req_o, mem_global_translation_table_o;
  logic        mem_ack_i, rst_ready_o;
  logic        cmd_valid_o, cmd_first_o, cmd_err_o;
  cbf_client_t cmd_client_o, f_cli;
  int          n_mismatch = 0, tests_run = 0, n_dw, n_hdr, n_gg;
  cbf_row_t    rows [10] = '{
    '{32'h0000_0000, 4'h1, 4'h2, CBF_CLI_MEMIF, 1'b0},
    '{32'h0280_0003, 4'h1, 4'h2, CBF_CLI_MEMIF, 1'b0},
    '{32'h0900_0001, 4'h3, 4'h4, CBF_CLI_MEMIF, 1'b0},
    '{32'h4000_0000, 4'h2, 4'h2, CBF_CLI_ENGINE, 1'b0},
    '{32'h6000_0001, 4'h3, 4'h4, CBF_CLI_ENGINE, 1'b0},
    '{32'h2000_0000, 4'h1, 4'h1, CBF_CLI_NONE, 1'b1},
    '{32'h8000_0000, 4'h1, 4'h1, CBF_CLI_NONE, 1'b1},
    '{32'ha000_0000, 4'h1, 4'h1, CBF_CLI_NONE, 1'b1},
    '{32'hc000_0000, 4'h1, 4'h1, CBF_CLI_NONE, 1'b1},
    '{32'he000_0000, 4'h1, 4'h1, CBF_CLI_NONE, 1'b1}};
  always #2 clk_i = ~clk_i;
  cbf_fetch_parse u_cbf_fetch_parse (.*);
  cbf_mem_model u_cbf_mem_model (.clk_i, .rst_n_i, .mem_req_o, .mem_addr_o,
    .gap_i(gap), .ack_o(mem_ack_i), .data_o(mem_data_i));
  // ****************************************
  // monitor and shared tasks
  // ****************************************
  always @(posedge clk_i) begin
    if (mem_req_o && mem_ack_i && mem_global_translation_table_o) n_gg++;
    if (cmd_valid_o === 1'b1) begin
      n_dw++;
      if (cmd_first_o === 1'b1 && n_hdr == 0) {f_cli, f_dat} = {cmd_client_o, cmd_data_o};
      if (cmd_first_o === 1'b1) n_hdr++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] w[]);
    foreach (w[i]) u_cbf_mem_model.mem[a[13:2] + 12'(i)] = w[i];
  endtask
  // fetch stops on its own; wait bounded for the request to fall
  task automatic drain;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 300 && mem_req_o !== 1'b0; k++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  // ring sits on a 4KB boundary; sequences padded to whole qwords
  task automatic ring(input logic [31:0] w[]);
    put(32'h1000 + tail, w);
    tail += 32'(4 * w.size());
    {n_dw, n_hdr, n_gg} = 0;
    wr(REG_RING_TAIL, tail);
    drain();
  endtask
  task automatic restore(input logic [3:0] ctl, input logic [31:0] post);
    int k;
    {n_dw, n_hdr, n_gg} = 0;
    wr(REG_CTRL, {28'h0, ctl});
    for (int i = 0; i < 32; i++) begin
      rst_word_i <= 1'b1;
      rst_data_i <= (i == 7) ? post : 32'h0;
      k = 0;
      @(negedge clk_i);
      while (rst_ready_o !== 1'b1 && k < 300) begin
        @(negedge clk_i);
        k++;
      end
      @(posedge clk_i);
      chk(32'(k < 300), 32'h1);
    end
    rst_word_i <= 1'b0;
    rst_data_i <= 32'hffff_ffff;
    drain();
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(4 * 40000);
    n_mismatch++;
    results();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [31:0] w[];
    tail = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({mem_req_o, cmd_valid_o, cmd_err_o, cmd_client_o}, 32'h2);
    rd(REG_RING_BASE, 32'h0);
    wr(REG_RING_LEN, 32'h0040_0000);
    rd(REG_RING_LEN, RING_MAX_B);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    wr(REG_RING_BASE, 32'h0000_1000);
    wr(REG_RING_LEN, 32'h0000_1000);
    wr(REG_CTRL, 32'h1);
    foreach (rows[r]) begin
      w = new[(rows[r].len + 1) & 4'he];
      foreach (w[i]) w[i] = (i == 0) ? rows[r].hdr : (i < rows[r].len) ? 32'h5a5a_0000 + i : 32'h0;
      ring(w);
      chk(n_dw, rows[r].dw);
      chk(cmd_err_o, rows[r].err);
      if (!rows[r].err) chk(f_dat, rows[r].hdr);
      if (!rows[r].err) chk(f_cli, rows[r].cli);
      if (rows[r].err) wr(REG_STATUS, 32'h1);
    end
    put(32'h2000, '{32'h4000_0000, 32'h5a5a_0001, 32'h0500_0000, 32'h0});
    ring('{32'h1880_0000, 32'h0000_2004});
    chk(n_dw, 2);
    chk(f_dat, 32'h4000_0000);
    put(32'h2400, '{32'h4000_0000, 32'h1, 32'h4000_0000, 32'h2, 32'h4000_0000});
    put(32'h2800, '{32'h6000_0001, 32'h1, 32'h2, 32'h0, 32'h0500_0000, 32'h0});
    wr(REG_INS_PTR, 32'h0000_2400);
    wr(REG_INS_SIZE, 32'h0000_0010);
    wr(REG_INS_OFS, 32'h0000_0040);
    wr(REG_RST_LEN, 32'h0000_0080);
    gap <= 2'h2;
    restore(4'h7, 32'h0000_2801);
    chk(n_dw, 8);
    chk(f_dat, 32'h4000_0000);
    chk(n_hdr, 4);
    chk(32'(n_gg != 0), 32'h1);
    gap <= 2'h0;
    restore(4'h3, 32'h0000_2800);
    chk(n_dw, 0);
    results();
  end
endmodule
`default_nettype wire
